// ===== core/cta_pkg.sv
/*
 * constants, field layouts and types shared by the counter array control
 * block and its per-module compare/capture unit.
 * assumes a 32-bit apb register port and five compare/capture modules.
 */
package cta_pkg;
    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_MOD = 5;
    localparam int CNT_W   = 16;
    localparam int LOW_W   = 8;
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int MODE_W  = 7;
    localparam int IDX_W   = 3;
    localparam int WDT_MOD = 4;   // module that carries the watchdog

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CMODE  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CCTRL  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_MMODE  = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_CAP    = 8'h40;
    localparam logic [ADDR_W-1:0] BANK_SPAN  = 8'h14;

    // ------------------------------------------------------------------
    // counter mode fields
    // ------------------------------------------------------------------
    localparam int CM_IDLE = 7;
    localparam int CM_WDT  = 6;
    localparam int CM_SRC1 = 2;
    localparam int CM_SRC0 = 1;
    localparam int CM_OVIE = 0;
    localparam logic [7:0] CMODE_MASK = 8'hC7;
    localparam logic [7:0] CMODE_RST  = 8'h00;

    // counter control fields: overflow flag, run bit, module flags
    localparam int CC_OVF = 7;
    localparam int CC_RUN = 6;

    // module mode fields
    localparam int MM_CMP   = 6;
    localparam int MM_RISE  = 5;
    localparam int MM_FALL  = 4;
    localparam int MM_MATCH = 3;
    localparam int MM_TOG   = 2;
    localparam int MM_PWM   = 1;
    localparam int MM_IE    = 0;
    localparam logic [MODE_W-1:0] MMODE_RST = 7'h00;

    // ------------------------------------------------------------------
    // count source prescale
    // ------------------------------------------------------------------
    localparam int DIV12 = 12;
    localparam int DIV4  = 4;
    localparam logic [3:0] DIV12_LAST = 4'(DIV12 - 1);
    localparam logic [3:0] DIV4_LAST  = 4'(DIV4 - 1);
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

    typedef enum logic [1:0] {
        SRC_DIV12 = 2'h0,
        SRC_DIV4  = 2'h1,
        SRC_T0    = 2'h2,
        SRC_EXT   = 2'h3
    } cta_src_t;
endpackage : cta_pkg

// ===== core/cta_unit.sv
/*
 * one compare/capture module: capture register, comparator, pin toggle
 * and pulse width output.
 * assumes the counter and its advance pulse come from the pclk domain;
 * the module pin input is asynchronous and is synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none
module cta_unit
    import cta_pkg::*;
(
    input  wire logic              pclk,      // core clock
    input  wire logic              presetn,   // async reset, low
    input  wire logic              ce,        // clock enable
    input  wire logic [MODE_W-1:0] mode,      // module mode bits
    input  wire logic [CNT_W-1:0]  cnt,       // array counter
    input  wire logic              cnt_new,   // counter just moved
    input  wire logic              cap_we,    // software load
    input  wire logic [CNT_W-1:0]  cap_wdata, // software value
    input  wire logic              pin_i,     // module pin level
    output logic                   evt,       // flag set pulse
    output logic [CNT_W-1:0]       cap_q,     // compare/capture value
    output logic                   pin_o,     // module pin drive
    output logic                   pin_oe     // module pin enable
);
    import cta_pkg::*;

    logic             s1_q, s2_q, s3_q;
    logic             tog_q, tog_d;
    logic             pin_q, pin_d;
    logic [CNT_W-1:0] cap_d;
    logic             hit, rise, fall, capt;

    // ------------------------------------------------------------------
    // compare, capture and pin logic
    // ------------------------------------------------------------------
    // only count values freshly reached compare, so a stalled counter
    // does not raise the same match over and over
    always_comb begin
        hit   = mode[MM_CMP] && cnt_new && (cnt == cap_q);
        rise  = s2_q && !s3_q;
        fall  = !s2_q && s3_q;
        capt  = (rise && mode[MM_RISE]) ||
                (fall && mode[MM_FALL]);
        cap_d = cap_q;
        if (cap_we) begin
            cap_d = cap_wdata;
        end else if (capt) begin
            cap_d = cnt;
        end
        evt   = capt || (hit && mode[MM_MATCH]);
        tog_d = tog_q ^ (hit && mode[MM_TOG]);
        // pwm: low while the low byte is below the compare low byte
        if (mode[MM_PWM]) begin
            pin_d = (cnt[LOW_W-1:0] >= cap_q[LOW_W-1:0]);
        end else begin
            pin_d = tog_d;
        end
    end

    // registers; the first sync stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            tog_q <= 1'b0;
            pin_q <= 1'b0;
            cap_q <= '0;
        end else if (ce) begin
            s1_q  <= pin_i;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            tog_q <= tog_d;
            pin_q <= pin_d;
            cap_q <= cap_d;
        end
    end

    assign pin_o  = pin_q;
    assign pin_oe = mode[MM_TOG] || mode[MM_PWM];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_no_cmp;
        !mode[MM_CMP] && !capt |-> !evt;
    endproperty
    a_no_cmp: assert property (p_no_cmp)
        else $error("event without comparator or capture");

    property p_rise_cap;
        ce && !cap_we && rise && mode[MM_RISE] |=> cap_q == $past(cnt);
    endproperty
    a_rise_cap: assert property (p_rise_cap)
        else $error("rising edge did not capture counter");

    property p_fall_cap;
        ce && !cap_we && fall && mode[MM_FALL]
            |=> cap_q == $past(cnt) ##1 1'b1;
    endproperty
    a_fall_cap: assert property (p_fall_cap)
        else $error("falling edge did not capture counter");

    property p_toggle;
        ce && hit && mode[MM_TOG] && !mode[MM_PWM] |=> pin_o != $past(pin_o);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("pin did not toggle on match");

    property p_pwm;
        ce && mode[MM_PWM] && $stable(mode)
            |=> pin_o == ($past(cnt[LOW_W-1:0]) >= $past(cap_q[LOW_W-1:0]));
    endproperty
    a_pwm: assert property (p_pwm)
        else $error("pwm level wrong");

    c_capture: cover property (ce && capt);
    c_toggle:  cover property (ce && hit && mode[MM_TOG]);
endmodule : cta_unit
`default_nettype wire

// ===== core/cta_ctrl.sv
/*
 * counter array control: counter mode register, counter control flags,
 * the array counter with its count source, five compare/capture modules,
 * watchdog hook on module 4, interrupt mask and an apb register port.
 * assumes pclk is the oscillator clock; idle and the timer 0 overflow
 * pulse come from pclk logic; the external count pin and module pins are
 * asynchronous.
 */
// Overview of operation
// - with the idle gate bit set the counter stops while idle.
// - clearing the watchdog enable bit stops module 4 resets.
// - the source field picks clk/12, clk/4, timer 0 or the pin.
// - the overflow flag requests an interrupt only when enabled.
// - module mode bit 7 is reserved, bits 6..0 are the mode bits.
// - the comparator enable turns on the counter compare.
// - the rising capture bit captures on a rising pin edge.
// - the falling capture bit captures on a falling pin edge.
// - a match with the match bit set raises the module flag.
// - a match with the toggle bit set and the pwm bit clear inverts the module pin.
// - the pwm bit makes the module pin a pulse width output.
// - the module interrupt enable gates the module flag.
`timescale 1ns/10ps
`default_nettype none
module cta_ctrl
    import cta_pkg::*;
(
    input  wire logic               pclk,     // oscillator clock
    input  wire logic               presetn,  // async reset, low
    input  wire logic               ce,       // clock enable
    input  wire logic               psel,     // apb select
    input  wire logic               penable,  // apb access phase
    input  wire logic               pwrite,   // apb write
    input  wire logic [ADDR_W-1:0]  paddr,    // apb byte address
    input  wire logic [DATA_W-1:0]  pwdata,   // apb write data
    output logic      [DATA_W-1:0]  prdata,   // apb read data
    output logic                    pready,   // apb ready
    output logic                    pslverr,  // apb error
    input  wire logic               idle,     // core idle mode
    input  wire logic               t0_ovf,   // timer 0 overflow
    input  wire logic               ext_cnt,  // external count pin
    input  wire logic [NUM_MOD-1:0] cex_i,    // module pins in
    output logic      [NUM_MOD-1:0] cex_o,    // module pins out
    output logic      [NUM_MOD-1:0] cex_oe,   // module pins enable
    output logic                    irq,      // interrupt level
    output logic                    wdt_rst   // watchdog reset pulse
);
    import cta_pkg::*;

    // ------------------------------------------------------------------
    // address decoding
    // ------------------------------------------------------------------
    function automatic logic in_bank(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] off;
        off = a - base;
        return (a >= base) && (off < BANK_SPAN);
    endfunction : in_bank

    function automatic logic [IDX_W-1:0] bank_idx(
            input logic [ADDR_W-1:0] a,
            input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] off;
        off = a - base;
        return off[IDX_W+1:2];
    endfunction : bank_idx

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        return (a == OFS_CMODE) || (a == OFS_CCTRL) ||
               (a == OFS_COUNT) || (a == OFS_MASK) ||
               in_bank(a, OFS_MMODE) || in_bank(a, OFS_CAP);
    endfunction : addr_ok

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]         cmode_q, cmode_d;
    logic [7:0]         mask_q, mask_d;
    logic               run_q, run_d;
    logic               ovf_q, ovf_d;
    logic [NUM_MOD-1:0] mflag_q, mflag_d;
    logic [CNT_W-1:0]   cnt_q, cnt_d;
    logic               new_q, new_d;
    logic [3:0]         pre_q, pre_d;
    logic               e1_q, e2_q, e3_q;
    logic               wdt_q, wdt_d;
    logic [DATA_W-1:0]  rd_q, rd_d;
    logic [MODE_W-1:0]  mmode_q [NUM_MOD];
    logic [MODE_W-1:0]  mmode_d [NUM_MOD];

    logic               wr, setup, gate, tick, pre_end;
    logic [3:0]         pre_last;
    cta_src_t           src;
    logic [NUM_MOD-1:0] evt, ie_vec;
    logic [NUM_MOD-1:0] cap_we;
    logic [CNT_W-1:0]   cap_val [NUM_MOD];

    assign wr     = psel && penable && pwrite;
    assign setup  = psel && !penable;
    assign src    = cta_src_t'({cmode_q[CM_SRC1], cmode_q[CM_SRC0]});

    // ------------------------------------------------------------------
    // count source and gating
    // ------------------------------------------------------------------
    // prescaler wraps at the divide chosen; it free runs so a source
    // change takes effect within one prescale period
    always_comb begin
        pre_last = (src == SRC_DIV4) ? DIV4_LAST : DIV12_LAST;
        pre_end  = (pre_q >= pre_last);
        pre_d    = pre_end ? 4'h0 : 4'(pre_q + 4'h1);
        gate     = run_q && !(idle && cmode_q[CM_IDLE]);
        case (src)
            SRC_DIV12: tick = pre_end;
            SRC_DIV4:  tick = pre_end;
            SRC_T0:    tick = t0_ovf;
            default:   tick = e2_q && !e3_q; // pin rising edge
        endcase
        tick = tick && gate;
    end

    // ------------------------------------------------------------------
    // register writes, counter and flags
    // ------------------------------------------------------------------
    // an event in the same cycle as a clearing write keeps its flag
    always_comb begin
        cmode_d = cmode_q;
        mask_d  = mask_q;
        run_d   = run_q;
        cnt_d   = cnt_q;
        new_d   = 1'b0;
        ovf_d   = ovf_q;
        mflag_d = mflag_q;
        cap_we  = '0;
        for (int i = 0; i < NUM_MOD; i++) begin
            mmode_d[i] = mmode_q[i];
        end
        if (wr) begin
            if (paddr == OFS_CMODE) begin
                cmode_d = pwdata[7:0] & CMODE_MASK;
            end else if (paddr == OFS_CCTRL) begin
                run_d   = pwdata[CC_RUN];
                ovf_d   = ovf_q && !pwdata[CC_OVF];
                mflag_d = mflag_q & ~pwdata[NUM_MOD-1:0];
            end else if (paddr == OFS_COUNT) begin
                cnt_d   = pwdata[CNT_W-1:0];
            end else if (paddr == OFS_MASK) begin
                mask_d  = pwdata[7:0];
            end else if (in_bank(paddr, OFS_MMODE)) begin
                mmode_d[bank_idx(paddr, OFS_MMODE)] =
                    pwdata[MODE_W-1:0];
            end else if (in_bank(paddr, OFS_CAP)) begin
                cap_we[bank_idx(paddr, OFS_CAP)] = 1'b1;
            end
        end
        if (tick && !(wr && paddr == OFS_COUNT)) begin
            cnt_d = 16'(cnt_q + 16'h1);
            new_d = 1'b1;
            if (cnt_q == CNT_MAX) begin
                ovf_d = 1'b1;
            end
        end
        mflag_d = mflag_d | evt;
        // module 4 match resets the core only while enabled
        wdt_d = cmode_q[CM_WDT] && evt[WDT_MOD]
                && mmode_q[WDT_MOD][MM_MATCH];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmode_q <= CMODE_RST;
            mask_q  <= '0;
            run_q   <= 1'b0;
            cnt_q   <= '0;
            new_q   <= 1'b0;
            ovf_q   <= 1'b0;
            mflag_q <= '0;
            pre_q   <= '0;
            wdt_q   <= 1'b0;
            for (int i = 0; i < NUM_MOD; i++) begin
                mmode_q[i] <= MMODE_RST;
            end
        end else if (ce) begin
            cmode_q <= cmode_d;
            mask_q  <= mask_d;
            run_q   <= run_d;
            cnt_q   <= cnt_d;
            new_q   <= new_d;
            ovf_q   <= ovf_d;
            mflag_q <= mflag_d;
            pre_q   <= pre_d;
            wdt_q   <= wdt_d;
            for (int i = 0; i < NUM_MOD; i++) begin
                mmode_q[i] <= mmode_d[i];
            end
        end
    end

    // external count pin: two stages before any logic, third for edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            e1_q <= 1'b0;
            e2_q <= 1'b0;
            e3_q <= 1'b0;
        end else if (ce) begin
            e1_q <= ext_cnt;
            e2_q <= e1_q;
            e3_q <= e2_q;
        end
    end

    // ------------------------------------------------------------------
    // compare/capture modules
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
        cta_unit u_unit (
            .pclk      (pclk),
            .presetn   (presetn),
            .ce        (ce),
            .mode      (mmode_q[g]),
            .cnt       (cnt_q),
            .cnt_new   (new_q),
            .cap_we    (cap_we[g]),
            .cap_wdata (pwdata[CNT_W-1:0]),
            .pin_i     (cex_i[g]),
            .evt       (evt[g]),
            .cap_q     (cap_val[g]),
            .pin_o     (cex_o[g]),
            .pin_oe    (cex_oe[g])
        );
        assign ie_vec[g] = mmode_q[g][MM_IE];
    end

    // ------------------------------------------------------------------
    // read data and interrupt
    // ------------------------------------------------------------------
    // read data is captured in the setup cycle so it leaves a flop
    always_comb begin
        rd_d = rd_q;
        if (setup) begin
            rd_d = '0;
            if (paddr == OFS_CMODE) begin
                rd_d[7:0] = cmode_q;
            end else if (paddr == OFS_CCTRL) begin
                rd_d[CC_OVF] = ovf_q;
                rd_d[CC_RUN] = run_q;
                rd_d[NUM_MOD-1:0] = mflag_q;
            end else if (paddr == OFS_COUNT) begin
                rd_d[CNT_W-1:0] = cnt_q;
            end else if (paddr == OFS_MASK) begin
                rd_d[7:0] = mask_q;
            end else if (in_bank(paddr, OFS_MMODE)) begin
                rd_d[MODE_W-1:0] = mmode_q[bank_idx(paddr, OFS_MMODE)];
            end else if (in_bank(paddr, OFS_CAP)) begin
                rd_d[CNT_W-1:0] = cap_val[bank_idx(paddr, OFS_CAP)];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_q <= '0;
        end else if (ce) begin
            rd_q <= rd_d;
        end
    end

    // zero wait states; a frozen clock enable stalls the bus
    assign prdata  = rd_q;
    assign pready  = ce;
    assign pslverr = psel && penable && !addr_ok(paddr);
    assign irq     = (ovf_q && cmode_q[CM_OVIE] && mask_q[CC_OVF])
                   || |(mflag_q & ie_vec & mask_q[NUM_MOD-1:0]);
    assign wdt_rst = wdt_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_idle;
        idle && cmode_q[CM_IDLE] && !wr |=> cnt_q == $past(cnt_q);
    endproperty
    a_idle: assert property (p_idle)
        else $error("counter moved while gated in idle");

    property p_wdt;
        wdt_rst |-> $past(cmode_q[CM_WDT]) && $past(evt[WDT_MOD]);
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog reset while disabled");

    property p_div4;
        ce && src == SRC_DIV4 && pre_q == DIV4_LAST ##1 ce [*4]
            |-> pre_q == DIV4_LAST || src != SRC_DIV4;
    endproperty
    a_div4: assert property (p_div4)
        else $error("divide by 4 prescale wrong");

    property p_src_t0;
        ce && gate && src == SRC_T0 && t0_ovf && !wr
            |=> cnt_q == 16'($past(cnt_q) + 16'h1);
    endproperty
    a_src_t0: assert property (p_src_t0)
        else $error("timer 0 overflow not counted");

    property p_ovf_irq;
        ovf_q && cmode_q[CM_OVIE] && mask_q[CC_OVF] |-> irq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq)
        else $error("enabled overflow gave no interrupt");

    property p_irq_cause;
        irq |-> (ovf_q && cmode_q[CM_OVIE]) || |(mflag_q & ie_vec);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without enabled cause");

    property p_rsvd;
        setup && in_bank(paddr, OFS_MMODE) |=> prdata[7] == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved mode bit read as one");

    property p_flag;
        ce && evt[0] |=> mflag_q[0];
    endproperty
    a_flag: assert property (p_flag)
        else $error("module event lost its flag");

    c_ovf:  cover property (ce && tick && cnt_q == CNT_MAX);
    c_wdt:  cover property (wdt_rst);
    c_ext:  cover property (ce && src == SRC_EXT && tick);
endmodule : cta_ctrl
`default_nettype wire

// ===== verif/testbench.sv
/*
 * self-checking bench for the counter array control block.
 * assumes a 20 MHz pclk, ce tied high and zero wait state apb.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import cta_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic idle = 0, t0_ovf = 0, ext_cnt = 0, pready, pslverr, irq, wdt_rst;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [4:0]  cex_i = 5'h00, cex_o, cex_oe;
    logic        er;
    int mismatches = 0, n_checks = 0, wdt_n = 0, i;
    logic [7:0]  ra[8] = '{8'h00, 8'h00, 8'h20, 8'h24, 8'h0C, 8'h08,
                           8'h44, 8'h10};
    logic [31:0] rw[8] = '{32'hFF, 32'h0, 32'hFF, 32'hAA, 32'hFF,
                           32'h1234, 32'hABCD, 32'hFF};
    logic [31:0] rx[8] = '{32'hC7, 32'h0, 32'h7F, 32'h2A, 32'hFF,
                           32'h1234, 32'hABCD, 32'h0};

    cta_ctrl i_cta_ctrl (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .idle(idle), .t0_ovf(t0_ovf),
        .ext_cnt(ext_cnt), .cex_i(cex_i), .cex_o(cex_o),
        .cex_oe(cex_oe), .irq(irq), .wdt_rst(wdt_rst));

    initial forever #25 pclk = ~pclk;
    // counts watchdog pulses; a pulse stands for one cycle only
    always @(posedge pclk) if (wdt_rst === 1'b1) wdt_n++;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    // one apb transfer; holds everything until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin mismatches++; summarize(); end
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb

    task automatic pulse;  // one timer 0 overflow, then let it settle
        @(posedge pclk) t0_ovf <= 1;
        @(posedge pclk) t0_ovf <= 0;
        repeat (3) @(posedge pclk);
    endtask : pulse

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        foreach (ra[j]) begin apb(0, ra[j], 0); chk(rd, 0); end
        for (i = 0; i < 8; i++) begin
            apb(1, ra[i], rw[i]);
            apb(0, ra[i], 0);
            chk(rd, rx[i]);
            chk(er, ra[i] == 8'h10);
        end
        $display("test registers done");
        // free running prescaled sources: about 48 pclk of counting
        apb(1, 8'h04, 32'h40);
        for (i = 0; i < 2; i++) begin
            apb(1, 8'h00, i ? 32'h0 : 32'h2);
            apb(1, 8'h08, 0);
            repeat (48) @(posedge pclk);
            apb(0, 8'h08, 0);
            chk(rd >= (i ? 3 : 11) && rd <= (i ? 5 : 13), 1);
        end
        // external pin, kept well under clk/8
        apb(1, 8'h00, 32'h6);
        apb(1, 8'h08, 0);
        repeat (3) begin
            @(posedge pclk) ext_cnt <= 1;
            repeat (6) @(posedge pclk);
            ext_cnt <= 0;
            repeat (6) @(posedge pclk);
        end
        apb(0, 8'h08, 0);
        chk(rd, 3);
        apb(1, 8'h00, 32'h4);
        apb(1, 8'h08, 0);
        repeat (3) pulse();
        apb(0, 8'h08, 0);
        chk(rd, 3);
        idle <= 1;
        apb(1, 8'h00, 32'h84);
        pulse();
        apb(0, 8'h08, 0);
        chk(rd, 3);
        apb(1, 8'h00, 32'h4);
        pulse();
        apb(0, 8'h08, 0);
        chk(rd, 4);
        idle <= 0;
        $display("test counting done");
        // module 0 off, else its match at the wrap keeps irq high
        apb(1, 8'h20, 0);
        apb(1, 8'h08, 32'hFFFF);
        apb(1, 8'h00, 32'h5);
        pulse();
        chk(irq, 1);
        apb(1, 8'h00, 32'h4);
        @(negedge pclk); // let the write land before looking at irq
        chk(irq, 0);
        apb(1, 8'h04, 32'hC0);
        // module 0 match at 5 with toggle and interrupt
        apb(1, 8'h40, 5);
        apb(1, 8'h08, 4);
        apb(1, 8'h20, 32'h4D);
        pulse();
        chk({cex_oe[0], cex_o[0], irq}, 3'h7);
        apb(0, 8'h04, 0);
        chk(rd & 32'h1F, 1);
        apb(1, 8'h20, 32'h4C);
        @(negedge pclk);
        chk(irq, 0);
        apb(1, 8'h04, 32'h41);
        // module 1 capture on both edges
        apb(1, 8'h24, 32'h30);
        @(posedge pclk) cex_i[1] <= 1;
        repeat (8) @(posedge pclk);
        apb(0, 8'h44, 0);
        chk(rd, 5);
        apb(0, 8'h04, 0);
        chk(rd & 32'h2, 2);
        pulse();
        cex_i[1] <= 0;
        repeat (8) @(posedge pclk);
        apb(0, 8'h44, 0);
        chk(rd, 6);
        $display("test modules done");
        apb(1, 8'h28, 32'h42);
        repeat (3) @(posedge pclk);
        chk({cex_oe[2], cex_o[2]}, 2'h3);
        apb(1, 8'h48, 32'hFF);
        repeat (3) @(posedge pclk);
        chk(cex_o[2], 0);
        // watchdog on module 4, then with it disabled
        apb(1, 8'h50, 8);
        apb(1, 8'h30, 32'h48);
        apb(1, 8'h00, 32'h44);
        apb(1, 8'h08, 7);
        pulse();
        chk(wdt_n, 1);
        apb(1, 8'h00, 32'h4);
        apb(1, 8'h08, 7);
        pulse();
        chk(wdt_n, 1);
        $display("test watchdog done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
